// ### verilog/lhx_link_ctrl.sv
// link-side controller for the phy parallel port: transmit handover and power
`timescale 1ns/1ps

module lhx_link_ctrl (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic arst_n_in,
  // user power control and multispeed concatenation enable
  input wire logic lps_on_in,
  input wire logic lps_pulsed_in,
  input wire logic multispeed_concat_enable_in,
  // user bus request
  input wire logic bus_req_in,
  // user transmit stream
  input wire logic tx_valid_in,
  input wire logic [7:0] tx_data_in,
  input wire logic tx_last_in,
  input wire logic [1:0] tx_speed_in,
  input wire logic tx_concat_in,
  input wire logic tx_cancel_in,
  output logic tx_ready_out,
  // user status
  output logic link_ready_out,
  output logic port_owned_out,
  output logic iface_reset_out,
  output logic iface_disabled_out,
  // phy pins
  input wire logic [1:0] handshake_control_pair_in,
  output logic [1:0] handshake_control_pair_out,
  output logic handshake_control_pair_oe_out,
  input wire logic [7:0] byte_lane_in,
  output logic [7:0] byte_lane_out,
  output logic byte_lane_oe_out,
  output logic link_request_line_out,
  output logic link_power_status_out
);

  typedef struct packed {
    lhx_pkg::lhx_state_type state;
    logic [lhx_pkg::CNT_W-1:0] cnt;
    logic [5:0] hold_cnt;
    logic [1:0] ctl;
    logic [7:0] dat;
    logic oe;
    logic link_request_line;
    logic in_pkt;
    logic last_sent;
    logic own;
    logic [1:0] cur_spd;
    logic concat;
  } lhx_ctrl_type;

  lhx_ctrl_type st_reg;
  lhx_ctrl_type st_next;
  logic take_byte;
  logic concat_ok;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------

  // speed code for byte_lane, don't-care bits sent as zero
  function automatic logic [7:0] spd_code(input logic [1:0] spd);
    case (spd)
      lhx_pkg::SPD_S200: spd_code = lhx_pkg::SPD_CODE_S200;
      lhx_pkg::SPD_S400: spd_code = lhx_pkg::SPD_CODE_S400;
      default: spd_code = lhx_pkg::SPD_CODE_S100;
    endcase
  endfunction : spd_code

  // a slower S100 packet may not follow a faster one
  assign concat_ok = tx_concat_in && !(multispeed_concat_enable_in &&
                     tx_speed_in == lhx_pkg::SPD_S100 &&
                     st_reg.cur_spd != lhx_pkg::SPD_S100);

  // a byte is taken while driving, valid and not cancelled, until the last byte is sent
  assign take_byte = st_reg.state == lhx_pkg::ST_DRIVE && !tx_cancel_in && !st_reg.last_sent
                     && tx_valid_in && lps_on_in;

  // ----------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    st_next = st_reg;
    st_next.link_request_line = 1'b0;
    if (!lps_on_in) begin
      // drop the port at once, far inside the 1 us allowance
      st_next.state = lhx_pkg::ST_OFF;
      st_next.cnt = '0;
      st_next.oe = 1'b0;
      st_next.ctl = lhx_pkg::CTL_IDLE;
      st_next.dat = lhx_pkg::BYTE_ZERO;
      st_next.in_pkt = 1'b0;
      st_next.last_sent = 1'b0;
      st_next.own = 1'b0;
      if (st_reg.state == lhx_pkg::ST_OFF && st_reg.cnt != lhx_pkg::CNT_MAX) begin
        st_next.cnt = st_reg.cnt + 1'b1;
      end
    end else begin
      case (st_reg.state)
        lhx_pkg::ST_OFF: begin
          // reassert only once isolation circuits have had time to restore
          if (st_reg.cnt >= lhx_pkg::RESTORE_CNT) begin
            st_next.state = lhx_pkg::ST_INIT;
            st_next.oe = 1'b1;  // one low cycle early in initialisation
            st_next.ctl = lhx_pkg::CTL_IDLE;
            st_next.dat = lhx_pkg::BYTE_ZERO;
          end else begin
            st_next.cnt = st_reg.cnt + 1'b1;
          end
        end
        lhx_pkg::ST_INIT: begin
          st_next.oe = 1'b0;
          // the clock may take milliseconds to return; just wait for it
          if (handshake_control_pair_in == lhx_pkg::CTL_RECEIVE &&
              byte_lane_in == lhx_pkg::BYTE_DATA_ON) begin
            st_next.state = lhx_pkg::ST_INIT_RX;
          end
        end
        lhx_pkg::ST_INIT_RX: begin
          if (handshake_control_pair_in == lhx_pkg::CTL_IDLE) begin
            st_next.state = lhx_pkg::ST_READY;
          end
        end
        lhx_pkg::ST_READY: begin
          st_next.link_request_line = bus_req_in;
          if (handshake_control_pair_in == lhx_pkg::CTL_GRANT) begin
            st_next.state = lhx_pkg::ST_GNT;
            st_next.link_request_line = 1'b0;
          end
        end
        lhx_pkg::ST_GNT: begin
          // device idles one cycle, then we take over with a hold
          if (handshake_control_pair_in == lhx_pkg::CTL_IDLE) begin
            st_next.state = lhx_pkg::ST_DRIVE;
            st_next.oe = 1'b1;
            st_next.ctl = lhx_pkg::CTL_HOLD;  // no idle lead-in used
            st_next.dat = lhx_pkg::BYTE_ZERO;
            st_next.hold_cnt = 6'h1;
            st_next.in_pkt = 1'b0;
            st_next.last_sent = 1'b0;
            if (!st_reg.own) begin
              st_next.cur_spd = tx_speed_in;
            end
          end else begin
            st_next.state = lhx_pkg::ST_READY;
          end
        end
        lhx_pkg::ST_DRIVE: begin
          if (st_reg.last_sent) begin
            // terminating cycle: hold keeps the bus, idle gives it up
            st_next.state = lhx_pkg::ST_TAIL;
            st_next.concat = concat_ok;
            st_next.ctl = concat_ok ? lhx_pkg::CTL_HOLD : lhx_pkg::CTL_IDLE;
            st_next.dat = (concat_ok && multispeed_concat_enable_in) ?
                          spd_code(tx_speed_in) : lhx_pkg::BYTE_ZERO;
            if (concat_ok) begin
              st_next.cur_spd = tx_speed_in;
            end
          end else if (take_byte) begin
            st_next.ctl = lhx_pkg::CTL_TRANSMIT;
            st_next.dat = tx_data_in;
            st_next.in_pkt = 1'b1;
            st_next.last_sent = tx_last_in;
          end else if (st_reg.in_pkt) begin
            // underrun mid packet cannot be held; close it with idle
            st_next.state = lhx_pkg::ST_TAIL;
            st_next.concat = 1'b0;
            st_next.ctl = lhx_pkg::CTL_IDLE;
            st_next.dat = lhx_pkg::BYTE_ZERO;
          end else if (tx_cancel_in || st_reg.hold_cnt == lhx_pkg::HOLD_MAX) begin
            // a hold always leads, so two idles release the port
            st_next.state = lhx_pkg::ST_TAIL;
            st_next.concat = 1'b0;
            st_next.ctl = lhx_pkg::CTL_IDLE;
            st_next.dat = lhx_pkg::BYTE_ZERO;
          end else begin
            st_next.ctl = lhx_pkg::CTL_HOLD;
            st_next.hold_cnt = st_reg.hold_cnt + 6'h1;
          end
        end
        lhx_pkg::ST_TAIL: begin
          st_next.state = lhx_pkg::ST_RELEASE;
          st_next.ctl = lhx_pkg::CTL_IDLE;
          st_next.dat = lhx_pkg::BYTE_ZERO;
        end
        lhx_pkg::ST_RELEASE: begin
          // hand the port back; the device owns the turnaround idle
          st_next.state = lhx_pkg::ST_READY;
          st_next.oe = 1'b0;
          st_next.own = st_reg.concat;
          st_next.in_pkt = 1'b0;
          st_next.last_sent = 1'b0;
        end
        default: begin
          st_next.state = lhx_pkg::ST_OFF;
          st_next.oe = 1'b0;
        end
      endcase
    end
  end

  // state register
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------------------------------
  // power status pin
  // ----------------------------------------------------------------
  lhx_lps_gen u_lps (
    .clk_sys_in(clk_sys_in),
    .arst_n_in(arst_n_in),
    .enable_in(st_reg.state != lhx_pkg::ST_OFF),
    .pulsed_in(lps_pulsed_in),
    .lps_out(link_power_status_out)
  );

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign tx_ready_out = take_byte;
  assign handshake_control_pair_out = st_reg.ctl;
  assign handshake_control_pair_oe_out = st_reg.oe;
  assign byte_lane_out = st_reg.dat;
  assign byte_lane_oe_out = st_reg.oe;
  assign link_request_line_out = st_reg.link_request_line;  // low whenever off
  assign link_ready_out = st_reg.state == lhx_pkg::ST_READY;
  assign port_owned_out = st_reg.oe && st_reg.state != lhx_pkg::ST_INIT;
  // expected device view while power status is low
  assign iface_reset_out = st_reg.state == lhx_pkg::ST_OFF && st_reg.cnt >= lhx_pkg::RESET_CNT;
  assign iface_disabled_out = st_reg.state == lhx_pkg::ST_OFF &&
                              st_reg.cnt >= lhx_pkg::DISABLE_CNT;

endmodule : lhx_link_ctrl

// ### pkg/lhx_pkg.sv
// constants and types shared by the link-side port controller
package lhx_pkg;

  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_PS = 40000;
  localparam int LPS_HIGH_NS = 80;        // pulsed high phase, 0.021 .. 2.6 us
  localparam int LPS_LOW_NS = 120;        // pulsed low phase, 0.09 .. 2.6 us
  localparam int RESET_MAX_NS = 2680;     // power_off_reset_time, upper bound
  localparam int DISABLE_NS = 26110;      // power_off_disable_time
  localparam int RESTORE_NS = 23000;      // isolation restore time
  localparam int LPS_HIGH_CYC = (LPS_HIGH_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int LPS_LOW_CYC = (LPS_LOW_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int RESET_CYC = (RESET_MAX_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int DISABLE_CYC = (DISABLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int RESTORE_CYC = (RESTORE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int CNT_W = 10;
  localparam logic [CNT_W-1:0] RESET_CNT = CNT_W'(RESET_CYC);
  localparam logic [CNT_W-1:0] DISABLE_CNT = CNT_W'(DISABLE_CYC);
  localparam logic [CNT_W-1:0] RESTORE_CNT = CNT_W'(RESTORE_CYC);
  localparam logic [CNT_W-1:0] CNT_MAX = 10'h3ff;
  localparam logic [5:0] HOLD_MAX = 6'h2f;  // 47 hold cycles at most

  // ----------------------------------------------------------------
  // handshake_control_pair codes and byte_lane values
  // ----------------------------------------------------------------
  localparam logic [1:0] CTL_IDLE = 2'h0;
  localparam logic [1:0] CTL_HOLD = 2'h1;     // status when the device drives
  localparam logic [1:0] CTL_TRANSMIT = 2'h2; // receive when the device drives
  localparam logic [1:0] CTL_GRANT = 2'h3;
  localparam logic [1:0] CTL_RECEIVE = 2'h2;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [7:0] BYTE_DATA_ON = 8'hff;
  localparam logic [7:0] SPD_CODE_S100 = 8'h00;
  localparam logic [7:0] SPD_CODE_S200 = 8'h40;
  localparam logic [7:0] SPD_CODE_S400 = 8'h50;

  // user speed selection
  localparam logic [1:0] SPD_S100 = 2'h0;
  localparam logic [1:0] SPD_S200 = 2'h1;
  localparam logic [1:0] SPD_S400 = 2'h2;

  // ----------------------------------------------------------------
  // controller states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_OFF = 3'h0,
    ST_INIT = 3'h1,
    ST_INIT_RX = 3'h2,
    ST_READY = 3'h3,
    ST_GNT = 3'h4,
    ST_DRIVE = 3'h5,
    ST_TAIL = 3'h6,
    ST_RELEASE = 3'h7
  } lhx_state_type;

endpackage : lhx_pkg

// ### verilog/lhx_lps_gen.sv
// link_power_status driver: steady level or pulse train
`timescale 1ns/1ps

module lhx_lps_gen (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic arst_n_in,
  // control
  input wire logic enable_in,
  input wire logic pulsed_in,
  // pin
  output logic lps_out
);

  typedef struct packed {
    logic high;
    logic [1:0] cnt;
    logic lps;
  } lhx_lps_type;

  lhx_lps_type st_reg;
  lhx_lps_type st_next;

  // ----------------------------------------------------------------
  // phase counter; 80 ns high of 200 ns keeps duty at 40 %
  // ----------------------------------------------------------------
  always_comb begin
    st_next = st_reg;
    if (!enable_in) begin
      st_next.high = 1'b0;
      st_next.cnt = 2'h0;
      st_next.lps = 1'b0;
    end else if (!pulsed_in) begin
      st_next.high = 1'b1;
      st_next.cnt = 2'h0;
      st_next.lps = 1'b1;
    end else if (st_reg.high) begin
      // high phase ends after the high count
      if (st_reg.cnt == 2'(lhx_pkg::LPS_HIGH_CYC - 1)) begin
        st_next.high = 1'b0;
        st_next.cnt = 2'h0;
        st_next.lps = 1'b0;
      end else begin
        st_next.cnt = st_reg.cnt + 2'h1;
      end
    end else begin
      if (st_reg.cnt == 2'(lhx_pkg::LPS_LOW_CYC - 1) || !st_reg.lps && st_reg.cnt == 2'h3) begin
        st_next.high = 1'b1;
        st_next.cnt = 2'h0;
        st_next.lps = 1'b1;
      end else begin
        st_next.cnt = st_reg.cnt + 2'h1;
      end
    end
  end

  // state register
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign lps_out = st_reg.lps;

endmodule : lhx_lps_gen

// ### dv/lhx_link_asserts.sv
// concurrent checks on the link-side port controller pins
`timescale 1ns/1ps
module lhx_link_asserts (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic arst_n_in,
  // user side
  input wire logic lps_on_in,
  input wire logic lps_pulsed_in,
  input wire logic multispeed_concat_enable_in,
  input wire logic tx_valid_in,
  input wire logic [7:0] tx_data_in,
  input wire logic tx_ready_out,
  input wire logic link_ready_out,
  input wire logic iface_reset_out,
  // phy pins
  input wire logic [1:0] handshake_control_pair_in,
  input wire logic [1:0] handshake_control_pair_out,
  input wire logic handshake_control_pair_oe_out,
  input wire logic [7:0] byte_lane_out,
  input wire logic byte_lane_oe_out,
  input wire logic link_request_line_out,
  input wire logic link_power_status_out
);
  wire [1:0] ci = handshake_control_pair_in;
  wire [1:0] co = handshake_control_pair_out;
  wire oe = handshake_control_pair_oe_out;
  wire lps = link_power_status_out;
  logic [5:0] hold_reg;
  logic [9:0] low_reg;
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!arst_n_in);
  // run of holds we drive, and cycles power status has been low
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      hold_reg <= 6'h00;
      low_reg <= 10'h000;
    end else begin
      hold_reg <= (oe && co == lhx_pkg::CTL_HOLD) ? hold_reg + 6'h01 : 6'h00;
      low_reg <= lps ? 10'h000 : low_reg + {9'h000, low_reg != 10'h3ff};
    end
  end
  sequence s_grant;
    link_ready_out && lps_on_in && ci == lhx_pkg::CTL_GRANT ##1 ci == lhx_pkg::CTL_IDLE && lps_on_in;
  endsequence
  sequence s_pkt_end;
    oe && co == lhx_pkg::CTL_TRANSMIT ##1 oe && co == lhx_pkg::CTL_HOLD;
  endsequence
  a_grant_to_hold: assert property (s_grant |=> oe && co == lhx_pkg::CTL_HOLD)
    else $error("no hold after grant");
  a_byte_follows: assert property (oe && lps_on_in && tx_valid_in && tx_ready_out
    |=> co == lhx_pkg::CTL_TRANSMIT && byte_lane_out == $past(tx_data_in))
    else $error("accepted byte not sent");
  a_hold_bound: assert property (hold_reg <= lhx_pkg::HOLD_MAX)
    else $error("too many hold cycles");
  a_release_idle: assert property ($fell(oe) && $past(lps_on_in)
    |-> $past(co) == lhx_pkg::CTL_IDLE && $past(co, 2) != lhx_pkg::CTL_TRANSMIT)
    else $error("port released without idles");
  a_end_code: assert property (s_pkt_end |-> (multispeed_concat_enable_in
    ? byte_lane_out inside {8'h00, 8'h40, 8'h50} : byte_lane_out == 8'h00))
    else $error("bad byte in ending hold");
  a_drop_release: assert property (!lps_on_in |=> !oe && !link_request_line_out)
    else $error("port or request kept after power drop");
  // the pin generator sees the off state one edge after the controller does
  a_lps_follow: assert property (!lps_on_in |=> ##1 !lps)
    else $error("power status not dropped");
  a_lane_drop: assert property (!lps_on_in |=> !byte_lane_oe_out)
    else $error("byte lane kept after power drop");
  a_pulse_high: assert property ($rose(lps) && lps_pulsed_in ##1 lps_on_in |-> lps ##1 !lps)
    else $error("pulse high phase wrong");
  a_reset_late: assert property ($rose(iface_reset_out) |-> low_reg >= 10'd64)
    else $error("reset flagged too early");
endmodule : lhx_link_asserts

// ### dv/lhx_phy_model.sv
// behavioural phy at the far side of the parallel port
`timescale 1ns/1ps
module lhx_phy_model (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic arst_n_in,
  // link drive
  input wire logic [1:0] lctl_in,
  input wire logic lctl_oe_in,
  input wire logic [7:0] ldat_in,
  input wire logic ldat_oe_in,
  input wire logic link_request_line_in,
  input wire logic lps_in,
  // resolved pins
  output logic [1:0] ctl_out,
  output logic [7:0] dat_out
);
  logic [1:0] pctl, cap_ctl[$];
  logic [7:0] pdat, pat, cap_dat[$];
  logic poe, cat, prev_tx, seen;
  int low, up, g;
  // undriven lines wander; pattern avoids grant so no false handover
  assign ctl_out = lctl_oe_in ? lctl_in : poe ? pctl : pat[1:0];
  assign dat_out = ldat_oe_in ? ldat_in : poe ? pdat : pat;
  // port sequencing on rising edges
  always @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      poe <= 1'b1;
      pat <= 8'h55;
      low <= 999;
    end else begin
      pat <= ~pat;
      low <= lps_in ? 0 : low + 1; // short pulse lows never reach reset
      if (low >= 66) begin // reset or disabled: low, no requests, no status
        {poe, pctl, pdat, cat} <= {1'b1, 2'h0, 8'h00, 1'b0};
        up <= 0;
        g <= 0;
      end else if (up < 9) begin // init, receive with data-on on the eighth
        up <= up + 1;
        pctl <= (up == 7) ? lhx_pkg::CTL_RECEIVE : lhx_pkg::CTL_IDLE;
        pdat <= (up == 7) ? lhx_pkg::BYTE_DATA_ON : lhx_pkg::BYTE_ZERO;
      end else begin
        case (g)
          0: if (link_request_line_in || cat) {pctl, g} <= {lhx_pkg::CTL_GRANT, 32'd1};
          1: {pctl, cat, g} <= {lhx_pkg::CTL_IDLE, 1'b0, 32'd2};
          2: {poe, prev_tx, seen, g} <= {3'b000, 32'd3};
          3: if (lctl_oe_in) begin
            cap_ctl.push_back(lctl_in);
            cap_dat.push_back(ldat_in);
            if (prev_tx) cat <= (lctl_in == lhx_pkg::CTL_HOLD);
            prev_tx <= (lctl_in == lhx_pkg::CTL_TRANSMIT);
            seen <= 1'b1;
          end else if (seen) {poe, pctl, g} <= {1'b1, lhx_pkg::CTL_IDLE, 32'd4};
          default: g <= 0; // idle before anything new
        endcase
      end
    end
  end
endmodule : lhx_phy_model

// ### dv/tb_top.sv
// self-checking bench for the link-side port controller
`timescale 1ns/1ps
module tb_top;
  logic clk_sys_in, arst_n_in, lps_on, pul, msc, breq, tv, tl, tc, tx_cancel, chain;
  logic [7:0] td, sent[$], dq[$];
  logic [1:0] tsp, cq[$];
  wire trdy, lrdy, own, irst, idis, coe, doe, link_request_line, lps;
  wire [1:0] co, ci;
  wire [7:0] dout, din;
  int fail_count = 0;
  int tests_run = 0;
  int k;
  lhx_link_ctrl lhx_link_ctrl_i (.clk_sys_in(clk_sys_in), .arst_n_in(arst_n_in),
    .lps_on_in(lps_on), .lps_pulsed_in(pul), .multispeed_concat_enable_in(msc),
    .bus_req_in(breq), .tx_valid_in(tv), .tx_data_in(td), .tx_last_in(tl),
    .tx_speed_in(tsp), .tx_concat_in(tc), .tx_cancel_in(tx_cancel), .tx_ready_out(trdy),
    .link_ready_out(lrdy), .port_owned_out(own), .iface_reset_out(irst),
    .iface_disabled_out(idis), .handshake_control_pair_in(ci),
    .handshake_control_pair_out(co), .handshake_control_pair_oe_out(coe),
    .byte_lane_in(din), .byte_lane_out(dout), .byte_lane_oe_out(doe),
    .link_request_line_out(link_request_line), .link_power_status_out(lps));
  lhx_phy_model lhx_phy_model_i (.clk_sys_in(clk_sys_in), .arst_n_in(arst_n_in),
    .lctl_in(co), .lctl_oe_in(coe), .ldat_in(dout), .ldat_oe_in(doe), .link_request_line_in(link_request_line),
    .lps_in(lps), .ctl_out(ci), .dat_out(din));
  // 25 mhz clock
  initial begin
    clk_sys_in = 1'b0;
    forever #20 clk_sys_in = ~clk_sys_in;
  end
  // hang guard, far beyond the few thousand cycles expected
  initial begin
    #800000;
    fail_count++;
    $display("ERROR %0t watchdog expired", $time);
    tally_and_finish();
  end
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask : cmp
  // bounded wait on ready (rdy=1) or port ownership
  task automatic wait_sig(input bit rdy, input logic v, input int lim);
    int i;
    for (i = 0; i < lim && (rdy ? lrdy : own) !== v; i++) @(negedge clk_sys_in);
    cmp(8'(rdy ? lrdy : own), 8'(v));
  endtask : wait_sig
  // one ownership: n bytes, or none then cancel or starve of data
  task automatic send(input int n, input bit cat, input logic [1:0] sp, nsp, input bit cxl);
    int i, h;
    bit hold;
    lhx_phy_model_i.cap_ctl.delete();
    lhx_phy_model_i.cap_dat.delete();
    sent.delete();
    if (!chain) tsp = sp;
    hold = cat && !(msc && nsp == lhx_pkg::SPD_S100 && tsp != lhx_pkg::SPD_S100);
    breq = 1'b1;
    wait_sig(1'b0, 1'b1, 400);
    breq = 1'b0;
    for (i = 0; i < n; i++) begin
      sent.push_back(8'($urandom));
      {tv, td, tl} = {1'b1, sent[i], i == n - 1};
      for (h = 0; h < 60; h++) begin
        #1;
        if (trdy === 1'b1) break;
        @(negedge clk_sys_in);
      end
      @(negedge clk_sys_in);
    end
    {tv, tc, tsp} = {1'b0, cat, nsp};
    if (n == 0 && cxl) begin
      repeat (3) @(negedge clk_sys_in);
      tx_cancel = 1'b1;
    end
    wait_sig(1'b0, 1'b0, 300);
    {tc, tx_cancel} = 2'b00;
    cq = lhx_phy_model_i.cap_ctl;
    dq = lhx_phy_model_i.cap_dat;
    for (h = 0; h < cq.size() && cq[h] == lhx_pkg::CTL_HOLD; h++);
    if (n == 0) begin
      if (!cxl) cmp(8'(h), 8'd47);
      cmp(8'(cq.size()), 8'(h + 2));
      for (i = 0; i < 2; i++) cmp(8'(cq[h+i]), 8'(lhx_pkg::CTL_IDLE));
      hold = 1'b0;
    end else begin
      for (i = 0; i < n; i++) begin
        cmp(8'(cq[h+i]), 8'(lhx_pkg::CTL_TRANSMIT));
        cmp(dq[h+i], sent[i]);
      end
      cmp(8'(cq[h+n]), 8'(hold ? lhx_pkg::CTL_HOLD : lhx_pkg::CTL_IDLE));
      if (hold) cmp(dq[h+n], code_of(msc ? nsp : 2'h0));
      cmp(8'(cq[h+n+1]), 8'(lhx_pkg::CTL_IDLE));
      cmp(8'(cq.size()), 8'(h + n + 2));
    end
    chain = hold;
  endtask : send
  // expected speed code of a next packet
  function automatic logic [7:0] code_of(input logic [1:0] s);
    if (s == lhx_pkg::SPD_S400) return 8'h50;
    return (s == lhx_pkg::SPD_S200) ? 8'h40 : 8'h00;
  endfunction : code_of
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : tally_and_finish
  // corner cases first, then random packets, then power drop and restore
  initial begin
    {arst_n_in, lps_on, pul, msc, breq, tv, tl, tc, tx_cancel, chain, td, tsp} = '0;
    void'($urandom(76));
    repeat (10) @(negedge clk_sys_in);
    arst_n_in = 1'b1;
    lps_on = 1'b1;
    wait_sig(1'b1, 1'b1, 900);
    send(3, 1'b0, 2'h0, 2'h0, 1'b0);
    msc = 1'b1;
    send(2, 1'b1, 2'h1, 2'h2, 1'b0);
    send(4, 1'b1, 2'h2, 2'h0, 1'b0);
    send(0, 1'b0, 2'h0, 2'h0, 1'b1);
    send(0, 1'b0, 2'h0, 2'h0, 1'b0);
    for (k = 0; k < 8; k++) begin
      msc = 1'($urandom);
      send(1 + int'($urandom % 8), 1'($urandom), 2'($urandom % 3), 2'($urandom % 3), 1'b0);
    end
    send(1, 1'b0, 2'h0, 2'h0, 1'b0);
    {lps_on, breq} = 2'b01;
    repeat (80) @(negedge clk_sys_in);
    cmp(8'(irst), 8'h01);
    cmp(8'(idis), 8'h00);
    cmp(8'(link_request_line), 8'h00);
    {breq, pul, lps_on} = 3'b011;
    repeat (400) @(negedge clk_sys_in);
    cmp(8'(lps), 8'h00);
    wait_sig(1'b1, 1'b1, 600);
    send(2, 1'b0, 2'h1, 2'h1, 1'b0);
    lps_on = 1'b0;
    repeat (700) @(negedge clk_sys_in);
    cmp(8'(idis), 8'h01);
    {pul, lps_on} = 2'b01;
    wait_sig(1'b1, 1'b1, 900);
    tally_and_finish();
  end
endmodule : tb_top
bind lhx_link_ctrl lhx_link_asserts lhx_link_asserts_i (
  .clk_sys_in(clk_sys_in), .arst_n_in(arst_n_in), .lps_on_in(lps_on_in),
  .lps_pulsed_in(lps_pulsed_in), .multispeed_concat_enable_in(multispeed_concat_enable_in),
  .tx_valid_in(tx_valid_in), .tx_data_in(tx_data_in), .tx_ready_out(tx_ready_out),
  .link_ready_out(link_ready_out), .iface_reset_out(iface_reset_out),
  .handshake_control_pair_in(handshake_control_pair_in),
  .handshake_control_pair_out(handshake_control_pair_out),
  .handshake_control_pair_oe_out(handshake_control_pair_oe_out),
  .byte_lane_out(byte_lane_out), .byte_lane_oe_out(byte_lane_oe_out),
  .link_request_line_out(link_request_line_out),
  .link_power_status_out(link_power_status_out));
